/* File: rtl/baiu_pkg.sv */
// Purpose: shared constants and types for the bitwise AND execution unit
// Assumes: 200 MHz core clock, Avalon-MM register slave with 32-bit data
// Notes: byte offsets are word aligned
package baiu_pkg;
	// opcode patterns of the first instruction word
	localparam logic [11:0] OPC_ACC_IMM_HI = 12'h3e0;
	localparam logic [15:0] OPC_ACC_IMM16 = 16'h5608;
	localparam logic [7:0] OPC_ACC_MEM_HI = 8'h89;
	localparam logic [6:0] OPC_MEM_DST_HI = 7'h60;
	localparam logic [6:0] OPC_THREE_HI = 7'h66;
	localparam logic [15:0] OPC_IRQ_MASK = 16'h7626;
	localparam logic [15:0] OPC_IRQ_PEND = 16'h762f;
	localparam logic [4:0] FIXED_SHIFT = 5'h10;
	localparam int HALF_SEL_BIT = 8;
	// register map, byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_ACC = 8'h08;
	localparam logic [7:0] OFS_MASK = 8'h0c;
	localparam logic [7:0] OFS_PEND = 8'h10;
	localparam logic [7:0] OFS_RPT = 8'h14;
	// field positions
	localparam int CTRL_OBJ_MODE_BIT = 0;
	localparam int STAT_NEG_BIT = 0;
	localparam int STAT_ZERO_BIT = 1;
	localparam int STAT_BUSY_BIT = 2;
	// reset values
	localparam logic RST_OBJ_MODE = 1'b1;
	localparam logic [31:0] RST_ACC = 32'h0000_0000;
	localparam logic [15:0] RST_MASK = 16'h0000;
	localparam logic [15:0] RST_PEND = 16'h0000;
	localparam logic [7:0] RST_RPT = 8'h00;
	// one-hot sequencer states
	typedef enum logic [1:0] {
		BAIU_IDLE = 2'b01,
		BAIU_HOLD = 2'b10
	} baiu_state_t;
	// one issued instruction with its fetched operand
	typedef struct packed {
		logic [15:0] word1;
		logic [15:0] word2;
		logic [15:0] mem_operand_16;
	} baiu_insn_t;
	// condition flags
	typedef struct packed {
		logic neg;
		logic zero;
	} baiu_flags_t;
endpackage

/* File: rtl/baiu_flag_eval.sv */
// Purpose: negative and zero evaluation of a result of any width
// Assumes: purely combinational, used inside the AND unit
// Notes: sign taken from the top bit of the given width
`timescale 1ns/1ps
module baiu_flag_eval #(
	parameter int W = 32
) (
	input wire logic [W-1:0] value_in,
	output baiu_pkg::baiu_flags_t flags_out
);
	assign flags_out.neg = value_in[W-1];
	assign flags_out.zero = (value_in == '0);
endmodule

/* File: rtl/baiu_unit.sv */
// Purpose: execution of the bitwise AND instruction family with register slave
// Assumes: decode pipeline presents one instruction per accepted cycle
// Notes: memory operand arrives with the instruction, results leave as pulses
//
// Contract
// - AND ACC immediate, 4-bit shift, one cycle
// - AND ACC immediate shifted sixteen, one cycle
// - zero-extend, shift left, AND, write ACC
// - shift field zero means no shift
// - 32-bit destination: Z when result zero
// - ACC AND zero-extended memory operand
// - memory-operand ACC form always clears N
// - memory-operand ACC form repeats; last flags
// - other variants clear repeat count, run once
// - three-operand form writes chosen half
// - half destination: N bit 15, Z zero
// - mask AND takes two cycles, no flags
// - pending AND takes two cycles, no flags
// - hardware pending set beats instruction write
// - memory destination read-modify-write, one cycle
// - memory destination flags from written value
//
// Our own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module baiu_unit (
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wire logic INSN_VALID_IN,
	input wire baiu_pkg::baiu_insn_t INSN_IN,
	output logic INSN_READY_OUT,
	output logic DONE_OUT,
	output logic ILLEGAL_OUT,
	input wire logic REPEAT_LOAD_IN,
	input wire logic [7:0] REPEAT_COUNT_IN,
	input wire logic [15:0] IRQ_SET_IN,
	output logic [31:0] MAIN_SUM_OUT,
	output baiu_pkg::baiu_flags_t FLAGS_OUT,
	output logic [15:0] IRQ_MASK_OUT,
	output logic [15:0] IRQ_PENDING_OUT,
	output logic MEM_WE_OUT,
	output logic [15:0] MEM_WDATA_OUT,
	input wire logic [7:0] AVS_ADDRESS_IN,
	input wire logic AVS_READ_IN,
	input wire logic AVS_WRITE_IN,
	input wire logic [31:0] AVS_WRITEDATA_IN,
	input wire logic [3:0] AVS_BYTEENABLE_IN,
	output logic [31:0] AVS_READDATA_OUT,
	output logic AVS_WAITREQUEST_OUT
);
	baiu_pkg::baiu_state_t state_reg, state_next;
	logic [31:0] main_sum_register, main_sum_next;
	logic [15:0] irq_mask_register, irq_mask_next;
	logic [15:0] irq_pending_register, irq_pending_next;
	logic [7:0] repeat_count_reg, repeat_count_next;
	logic object_mode_bit, object_mode_next;
	baiu_pkg::baiu_flags_t flags_reg, flags_next;
	logic hold_is_pend_reg;
	logic [15:0] hold_imm_reg;
	logic done_reg, illegal_reg, mem_we_reg;
	logic [15:0] mem_wdata_reg;
	logic [31:0] readdata_reg;
	logic waitreq_reg;
	logic ready_reg;

	// decode of the issued word
	// unknown opcodes are taken and dropped without a done pulse
	wire [15:0] w1 = INSN_IN.word1;
	wire [15:0] w2 = INSN_IN.word2;
	wire [15:0] opnd = INSN_IN.mem_operand_16;
	wire is_acc_imm = (w1[15:4] == baiu_pkg::OPC_ACC_IMM_HI);
	wire is_acc_imm16 = (w1 == baiu_pkg::OPC_ACC_IMM16);
	wire is_acc_mem = (w1[15:8] == baiu_pkg::OPC_ACC_MEM_HI);
	wire is_mem_dst = (w1[15:9] == baiu_pkg::OPC_MEM_DST_HI);
	wire is_three = (w1[15:9] == baiu_pkg::OPC_THREE_HI);
	wire is_mask = (w1 == baiu_pkg::OPC_IRQ_MASK);
	wire is_pend = (w1 == baiu_pkg::OPC_IRQ_PEND);
	wire is_wide = is_acc_imm | is_acc_imm16 | is_acc_mem;
	wire is_known = is_wide | is_mem_dst | is_three | is_mask | is_pend;
	wire accept = INSN_VALID_IN & (state_reg == baiu_pkg::BAIU_IDLE);
	wire wide_ok = is_wide & object_mode_bit;
	wire bad_mode = accept & is_wide & ~object_mode_bit;
	wire run = accept & is_known & ~bad_mode;

	// 32-bit datapath
	wire [4:0] shift_amt = is_acc_imm16 ? baiu_pkg::FIXED_SHIFT : {1'b0, w1[3:0]};
	wire [31:0] imm_shifted = {16'h0000, w2} << shift_amt;
	wire [31:0] acc_imm_res = main_sum_register & imm_shifted;
	wire [31:0] acc_mem_res = main_sum_register & {16'h0000, opnd};
	wire [31:0] wide_res = is_acc_mem ? acc_mem_res : acc_imm_res;

	// half-word datapath; opcode bit set picks the upper half
	wire half_sel = w1[baiu_pkg::HALF_SEL_BIT];
	wire [15:0] upper_half_word = main_sum_register[31:16];
	wire [15:0] lower_half_word = main_sum_register[15:0];
	wire [15:0] selected_half_word = half_sel ? upper_half_word : lower_half_word;
	wire [15:0] three_res = opnd & w2;
	wire [15:0] mem_dst_res = opnd & selected_half_word;
	wire [15:0] half_res = is_three ? three_res : mem_dst_res;
	wire [31:0] acc_three = half_sel ? {three_res, lower_half_word} : {upper_half_word, three_res};

	baiu_pkg::baiu_flags_t wide_flags, half_flags;

	baiu_flag_eval #(.W(32)) u_wide_flags (
		.value_in(wide_res),
		.flags_out(wide_flags)
	);

	baiu_flag_eval #(.W(16)) u_half_flags (
		.value_in(half_res),
		.flags_out(half_flags)
	);

	// repeat handling: only the memory-operand ACC form counts down
	wire rpt_iter = run & is_acc_mem;
	wire rpt_last = (repeat_count_reg == 8'h00);
	wire upd_wide = run & wide_ok & (~is_acc_mem | rpt_last);
	wire upd_half = run & (is_three | is_mem_dst);

	// register slave decode; write lands at the edge waitrequest is seen low
	wire sel_ctrl = (AVS_ADDRESS_IN == baiu_pkg::OFS_CTRL);
	wire sel_status = (AVS_ADDRESS_IN == baiu_pkg::OFS_STATUS);
	wire sel_acc = (AVS_ADDRESS_IN == baiu_pkg::OFS_ACC);
	wire sel_mask = (AVS_ADDRESS_IN == baiu_pkg::OFS_MASK);
	wire sel_pend = (AVS_ADDRESS_IN == baiu_pkg::OFS_PEND);
	wire sel_rpt = (AVS_ADDRESS_IN == baiu_pkg::OFS_RPT);
	wire bus_req = AVS_READ_IN | AVS_WRITE_IN;
	wire bus_wr = AVS_WRITE_IN & ~waitreq_reg;
	wire wr_ctrl = bus_wr & sel_ctrl;
	wire wr_acc = bus_wr & sel_acc;
	wire wr_mask = bus_wr & sel_mask;
	wire hold_now = (state_reg == baiu_pkg::BAIU_HOLD);
	wire hold_mask_wr = hold_now & ~hold_is_pend_reg;
	wire hold_pend_wr = hold_now & hold_is_pend_reg;
	wire acc_by_insn = run & (is_wide | is_three);

	// byte-lane merge; lanes left disabled keep the register's old byte
	wire [31:0] mask_old = {16'h0000, irq_mask_register};
	wire [31:0] ctrl_old = {31'h0, object_mode_bit};
	wire [31:0] acc_sw;
	wire [31:0] mask_sw;
	wire [31:0] ctrl_sw;
	genvar lane;
	generate
		for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
			wire lane_on = AVS_BYTEENABLE_IN[lane];
			wire [7:0] lane_new = AVS_WRITEDATA_IN[8*lane +: 8];
			assign acc_sw[8*lane +: 8] = lane_on ? lane_new : main_sum_register[8*lane +: 8];
			assign mask_sw[8*lane +: 8] = lane_on ? lane_new : mask_old[8*lane +: 8];
			assign ctrl_sw[8*lane +: 8] = lane_on ? lane_new : ctrl_old[8*lane +: 8];
		end
	endgenerate

	// unmapped offsets read as zero so software can probe the map safely
	wire busy = ~ready_reg;
	wire [31:0] status_word = {29'h0, busy, flags_reg.zero, flags_reg.neg};
	wire [31:0] rd_mux =
		sel_ctrl ? ctrl_old :
		sel_status ? status_word :
		sel_acc ? main_sum_register :
		sel_mask ? mask_old :
		sel_pend ? {16'h0000, irq_pending_register} :
		sel_rpt ? {24'h0, repeat_count_reg} : 32'h0000_0000;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			baiu_pkg::BAIU_IDLE: begin
				if (run & (is_mask | is_pend)) begin
					state_next = baiu_pkg::BAIU_HOLD;
				end
			end
			baiu_pkg::BAIU_HOLD: begin
				state_next = baiu_pkg::BAIU_IDLE;
			end
			default: begin
				state_next = baiu_pkg::BAIU_IDLE;
			end
		endcase
	end

	// instruction result beats a same-cycle software write
	always_comb begin
		main_sum_next = main_sum_register;
		if (run & wide_ok) begin
			main_sum_next = wide_res;
		end else if (run & is_three) begin
			main_sum_next = acc_three;
		end else if (wr_acc & ~acc_by_insn) begin
			main_sum_next = acc_sw;
		end
	end

	// repeated passes leave the flags alone until the last one
	always_comb begin
		flags_next = flags_reg;
		if (upd_wide) begin
			flags_next.zero = wide_flags.zero;
			flags_next.neg = is_acc_mem ? 1'b0 : wide_flags.neg;
		end else if (upd_half) begin
			flags_next = half_flags;
		end
	end

	// a prefix load wins over a same-cycle issue
	always_comb begin
		repeat_count_next = repeat_count_reg;
		if (REPEAT_LOAD_IN) begin
			repeat_count_next = REPEAT_COUNT_IN;
		end else if (rpt_iter & ~rpt_last) begin
			repeat_count_next = repeat_count_reg - 8'h01;
		end else if (accept & is_known) begin
			repeat_count_next = 8'h00;
		end
	end

	// irq registers: pending set from hardware is ORed last so it always wins
	always_comb begin
		irq_mask_next = irq_mask_register;
		if (hold_mask_wr) begin
			irq_mask_next = irq_mask_register & hold_imm_reg;
		end else if (wr_mask) begin
			irq_mask_next = mask_sw[15:0];
		end
		irq_pending_next = irq_pending_register;
		if (hold_pend_wr) begin
			irq_pending_next = irq_pending_register & hold_imm_reg;
		end
		irq_pending_next = irq_pending_next | IRQ_SET_IN;
	end

	assign object_mode_next = wr_ctrl ? ctrl_sw[baiu_pkg::CTRL_OBJ_MODE_BIT] : object_mode_bit;

	// ready kept as its own flop so the port needs no decode
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			state_reg <= baiu_pkg::BAIU_IDLE;
			ready_reg <= 1'b1;
		end else begin
			state_reg <= state_next;
			ready_reg <= (state_next == baiu_pkg::BAIU_IDLE);
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			main_sum_register <= baiu_pkg::RST_ACC;
		end else begin
			main_sum_register <= main_sum_next;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			flags_reg <= '0;
		end else begin
			flags_reg <= flags_next;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			repeat_count_reg <= baiu_pkg::RST_RPT;
		end else begin
			repeat_count_reg <= repeat_count_next;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			irq_mask_register <= baiu_pkg::RST_MASK;
			irq_pending_register <= baiu_pkg::RST_PEND;
		end else begin
			irq_mask_register <= irq_mask_next;
			irq_pending_register <= irq_pending_next;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			object_mode_bit <= baiu_pkg::RST_OBJ_MODE;
		end else begin
			object_mode_bit <= object_mode_next;
		end
	end

	// two-cycle forms park their immediate for the second cycle
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			hold_is_pend_reg <= 1'b0;
			hold_imm_reg <= 16'h0000;
		end else if (run & (is_mask | is_pend)) begin
			hold_is_pend_reg <= is_pend;
			hold_imm_reg <= w2;
		end
	end

	// memory write of the read-modify-write form, one cycle after issue
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			mem_we_reg <= 1'b0;
			mem_wdata_reg <= 16'h0000;
		end else begin
			mem_we_reg <= run & is_mem_dst;
			mem_wdata_reg <= mem_dst_res;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			done_reg <= 1'b0;
			illegal_reg <= 1'b0;
		end else begin
			done_reg <= (run & ~is_mask & ~is_pend) | hold_now;
			illegal_reg <= bad_mode;
		end
	end

	// one wait cycle per access keeps the read mux off the output path
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			waitreq_reg <= 1'b1;
		end else begin
			waitreq_reg <= ~(bus_req & waitreq_reg);
		end
	end

	// read data stays put until the next read is taken
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			readdata_reg <= 32'h0000_0000;
		end else if (AVS_READ_IN & waitreq_reg) begin
			readdata_reg <= rd_mux;
		end
	end

	assign INSN_READY_OUT = ready_reg;
	assign DONE_OUT = done_reg;
	assign ILLEGAL_OUT = illegal_reg;
	assign MAIN_SUM_OUT = main_sum_register;
	assign FLAGS_OUT = flags_reg;
	assign IRQ_MASK_OUT = irq_mask_register;
	assign IRQ_PENDING_OUT = irq_pending_register;
	assign MEM_WE_OUT = mem_we_reg;
	assign MEM_WDATA_OUT = mem_wdata_reg;
	assign AVS_READDATA_OUT = readdata_reg;
	assign AVS_WAITREQUEST_OUT = waitreq_reg;
endmodule

/* File: testbench/baiu_unit_asserts.sv */
// Purpose: port checks of the AND execution unit
// Assumes: one clock, synchronous reset
// Notes: bound into baiu_unit
`timescale 1ns/1ps
module baiu_unit_asserts (
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wire logic INSN_VALID_IN,
	input wire baiu_pkg::baiu_insn_t INSN_IN,
	input wire logic INSN_READY_OUT,
	input wire logic DONE_OUT,
	input wire logic ILLEGAL_OUT,
	input wire logic [15:0] IRQ_SET_IN,
	input wire logic [31:0] MAIN_SUM_OUT,
	input wire baiu_pkg::baiu_flags_t FLAGS_OUT,
	input wire logic [15:0] IRQ_PENDING_OUT,
	input wire logic MEM_WE_OUT,
	input wire logic [15:0] MEM_WDATA_OUT
);
	default clocking @(posedge CLK_IN);
	endclocking
	default disable iff (RST_IN);
	wire logic tk = INSN_VALID_IN && INSN_READY_OUT;
	wire logic [15:0] w1 = INSN_IN.word1;
	wire logic [15:0] op = INSN_IN.mem_operand_16;
	wire logic sel = w1[8];
	wire logic [15:0] half = sel ? MAIN_SUM_OUT[31:16] : MAIN_SUM_OUT[15:0];
	wire logic [15:0] r3 = op & INSN_IN.word2;
	wire logic [1:0] f3 = {r3[15], r3 == 16'h0000};
	wire logic imm = tk && w1[15:4] == baiu_pkg::OPC_ACC_IMM_HI;
	wire logic [31:0] imm_sh = {16'h0000, INSN_IN.word2} << w1[3:0];
	wire logic thr = tk && w1[15:9] == baiu_pkg::OPC_THREE_HI;
	wire logic mdst = tk && w1[15:9] == baiu_pkg::OPC_MEM_DST_HI;
	property p_imm_res;
		imm |=> ILLEGAL_OUT || (DONE_OUT && MAIN_SUM_OUT == ($past(MAIN_SUM_OUT) & $past(imm_sh)));
	endproperty
	a_imm_res: assert property (p_imm_res) else $error("immediate and result wrong");
	property p_imm_flg;
		imm |=> ILLEGAL_OUT || FLAGS_OUT == {MAIN_SUM_OUT[31], MAIN_SUM_OUT == 32'h00000000};
	endproperty
	a_imm_flg: assert property (p_imm_flg) else $error("immediate and flags wrong");
	property p_mask;
		tk && w1 == baiu_pkg::OPC_IRQ_MASK |=> !INSN_READY_OUT ##1 (INSN_READY_OUT && DONE_OUT);
	endproperty
	a_mask: assert property (p_mask) else $error("mask and not two cycles");
	property p_pend;
		tk && w1 == baiu_pkg::OPC_IRQ_PEND |=> (!INSN_READY_OUT && $stable(FLAGS_OUT)) ##1 (DONE_OUT && $stable(FLAGS_OUT));
	endproperty
	a_pend: assert property (p_pend) else $error("pending and timing or flags wrong");
	// hardware set must survive any same-cycle instruction clear
	property p_hw;
		!$past(RST_IN) |-> (IRQ_PENDING_OUT & $past(IRQ_SET_IN)) == $past(IRQ_SET_IN);
	endproperty
	a_hw: assert property (p_hw) else $error("hardware pending set lost");
	property p_mdst;
		mdst |=> MEM_WE_OUT && MEM_WDATA_OUT == ($past(op) & $past(half));
	endproperty
	a_mdst: assert property (p_mdst) else $error("memory destination data wrong");
	property p_mflg;
		MEM_WE_OUT |-> FLAGS_OUT == {MEM_WDATA_OUT[15], MEM_WDATA_OUT == 16'h0000};
	endproperty
	a_mflg: assert property (p_mflg) else $error("memory destination flags wrong");
	property p_three;
		thr |=> DONE_OUT && ($past(sel) ? MAIN_SUM_OUT[31:16] : MAIN_SUM_OUT[15:0]) == $past(r3);
	endproperty
	a_three: assert property (p_three) else $error("three operand half wrong");
	property p_hflg;
		thr |=> FLAGS_OUT == $past(f3);
	endproperty
	a_hflg: assert property (p_hflg) else $error("half result flags wrong");
	c_imm: cover property (imm);
	c_hold: cover property (!INSN_READY_OUT);
	c_mwe: cover property (MEM_WE_OUT);
endmodule
bind baiu_unit baiu_unit_asserts i_chk (.CLK_IN, .RST_IN, .INSN_VALID_IN, .INSN_IN, .INSN_READY_OUT, .DONE_OUT,
	.ILLEGAL_OUT, .IRQ_SET_IN, .MAIN_SUM_OUT, .FLAGS_OUT, .IRQ_PENDING_OUT, .MEM_WE_OUT, .MEM_WDATA_OUT);

/* File: testbench/baiu_decode_model.sv */
// Purpose: decode pipeline that offers instructions to the unit
// Assumes: called right after a rising edge
// Notes: idle bus shows inverted data; two idle calls in a row show the stale word again
`timescale 1ns/1ps
module baiu_decode_model (
	input wire logic clk_in,
	input wire logic ready_in,
	output logic valid_out,
	output baiu_pkg::baiu_insn_t insn_out
);
	initial begin
		valid_out = 1'b0;
		insn_out = '0;
	end
	// held until taken; no release so back-to-back stays legal
	task automatic issue(input baiu_pkg::baiu_insn_t insn);
		valid_out <= 1'b1;
		insn_out <= insn;
		@(posedge clk_in);
		while (ready_in !== 1'b1) @(posedge clk_in);
	endtask
	task automatic idle();
		valid_out <= 1'b0;
		insn_out <= ~insn_out;
	endtask
endmodule

/* File: testbench/baiu_unit_test.sv */
// Purpose: self-checking bench of the AND execution unit
// Assumes: 200 MHz clock, byte enables always full
// Notes: expectations queued by the driver, popped on done or illegal
`timescale 1ns/1ps
module baiu_unit_test;
	typedef struct packed {
		logic [31:0] acc;
		logic [1:0] flg;
		logic [15:0] msk;
		logic [15:0] pnd;
		logic we;
		logic [15:0] wd;
		logic ill;
	} baiu_exp_t;
	logic CLK_IN = 1'b0;
	logic RST_IN = 1'b1;
	logic [7:0] AVS_ADDRESS_IN = 8'h00;
	logic AVS_READ_IN = 1'b0;
	logic AVS_WRITE_IN = 1'b0;
	logic [31:0] AVS_WRITEDATA_IN = 32'h0;
	logic REPEAT_LOAD_IN = 1'b0;
	logic [7:0] REPEAT_COUNT_IN = 8'h00;
	logic [15:0] IRQ_SET_IN = 16'h0;
	logic valid, INSN_READY_OUT, DONE_OUT, ILLEGAL_OUT, MEM_WE_OUT, AVS_WAITREQUEST_OUT;
	baiu_pkg::baiu_insn_t insn;
	baiu_pkg::baiu_flags_t FLAGS_OUT;
	logic [31:0] MAIN_SUM_OUT, AVS_READDATA_OUT, acc, q, lfsr = 32'h392ff5f6;
	logic [15:0] IRQ_MASK_OUT, IRQ_PENDING_OUT, MEM_WDATA_OUT, msk = 16'h0, pnd = 16'h0;
	logic [1:0] flg = 2'h0;
	logic [7:0] repeat_prefix_op = 8'h00;
	logic om = 1'b1;
	baiu_exp_t exp_q[$];
	baiu_exp_t m;
	int num_errors = 0, checks_done = 0, cyc = 0, i;
	always #2.5 CLK_IN = ~CLK_IN;
	baiu_unit i_dut (.CLK_IN, .RST_IN, .INSN_VALID_IN(valid), .INSN_IN(insn), .INSN_READY_OUT, .DONE_OUT,
		.ILLEGAL_OUT, .REPEAT_LOAD_IN, .REPEAT_COUNT_IN, .IRQ_SET_IN, .MAIN_SUM_OUT, .FLAGS_OUT, .IRQ_MASK_OUT,
		.IRQ_PENDING_OUT, .MEM_WE_OUT, .MEM_WDATA_OUT, .AVS_ADDRESS_IN, .AVS_READ_IN, .AVS_WRITE_IN,
		.AVS_WRITEDATA_IN, .AVS_BYTEENABLE_IN(4'hf), .AVS_READDATA_OUT, .AVS_WAITREQUEST_OUT);
	baiu_decode_model i_dec (.clk_in(CLK_IN), .ready_in(INSN_READY_OUT), .valid_out(valid), .insn_out(insn));
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return s[0] ? (s >> 1) ^ 32'h80200003 : s >> 1;
	endfunction
	task automatic print_verdict();
		if (num_errors == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic check(input string n, input logic [31:0] s, input logic [31:0] x);
		checks_done++;
		if (s !== x) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, x, s);
		end
	endtask
	// an edge first, so a new request never lands in the release step
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK_IN);
		AVS_ADDRESS_IN <= a;
		AVS_WRITE_IN <= wr;
		AVS_READ_IN <= !wr;
		AVS_WRITEDATA_IN <= d;
		do @(posedge CLK_IN); while (AVS_WAITREQUEST_OUT !== 1'b0);
		q = AVS_READDATA_OUT;
		AVS_WRITE_IN <= 1'b0;
		AVS_READ_IN <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		bus(1'b0, a, 32'h0);
		check("register", q, x);
	endtask
	task automatic run(input logic [15:0] w1, input logic [15:0] w2, input logic [15:0] op);
		baiu_exp_t e;
		logic [15:0] r;
		logic imm, acm;
		imm = w1[15:4] == 12'h3e0 || w1 == 16'h5608;
		acm = w1[15:8] == 8'h89;
		r = (w1[8] ? acc[31:16] : acc[15:0]) & op;
		e = '0;
		if ((imm || acm) && !om) e.ill = 1'b1;
		else if (w1[15:4] == 12'h3e0) acc = acc & ({16'h0, w2} << w1[3:0]);
		else if (imm) acc = acc & {w2, 16'h0};
		else if (acm) acc = acc & {16'h0, op};
		else if (w1[15:9] == 7'h60) begin
			e.we = 1'b1;
			e.wd = r;
			flg = {r[15], r == 16'h0};
		end else if (w1[15:9] == 7'h66) begin
			r = op & w2;
			if (w1[8]) acc[31:16] = r;
			else acc[15:0] = r;
			flg = {r[15], r == 16'h0};
		end else if (w1 == 16'h7626) msk = msk & w2;
		else pnd = (pnd & w2) | IRQ_SET_IN;
		if (imm && !e.ill) flg = {acc[31], acc == 32'h0};
		if (acm && !e.ill && repeat_prefix_op == 8'h00) flg = {1'b0, acc == 32'h0};
		repeat_prefix_op = (acm && !e.ill && repeat_prefix_op != 8'h00) ? repeat_prefix_op - 8'h01 : 8'h00;
		e.acc = acc;
		e.flg = flg;
		e.msk = msk;
		e.pnd = pnd;
		exp_q.push_back(e);
		i_dec.issue({w1, w2, op});
	endtask
	task automatic load_rpt(input logic [7:0] n);
		i_dec.idle();
		REPEAT_COUNT_IN <= n;
		REPEAT_LOAD_IN <= 1'b1;
		@(posedge CLK_IN);
		REPEAT_LOAD_IN <= 1'b0;
		repeat_prefix_op = n;
	endtask
	task automatic set_acc(input logic [31:0] v);
		i_dec.idle();
		bus(1'b1, 8'h08, v);
		acc = v;
	endtask
	always @(posedge CLK_IN) begin
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			print_verdict();
		end
	end
	always @(posedge CLK_IN) begin
		if (DONE_OUT === 1'b1 || ILLEGAL_OUT === 1'b1) begin
			m = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
			check("acc", MAIN_SUM_OUT, m.acc);
			check("flags", {30'h0, FLAGS_OUT}, {30'h0, m.flg});
			check("mask", {16'h0, IRQ_MASK_OUT}, {16'h0, m.msk});
			check("pending", {16'h0, IRQ_PENDING_OUT}, {16'h0, m.pnd});
			check("illegal", {31'h0, ILLEGAL_OUT}, {31'h0, m.ill});
			check("write enable", {31'h0, MEM_WE_OUT}, {31'h0, m.we});
			if (m.we) check("write data", {16'h0, MEM_WDATA_OUT}, {16'h0, m.wd});
		end
	end
	initial begin
		repeat (6) @(posedge CLK_IN);
		RST_IN <= 1'b0;
		rd(8'h00, 32'h1);
		rd(8'h08, 32'h0);
		bus(1'b1, 8'h40, lfsr);
		rd(8'h40, 32'h0);
		for (i = 0; i < 17; i++) begin
			lfsr = nxt(lfsr);
			set_acc(lfsr);
			run(i < 16 ? {12'h3e0, i[3:0]} : 16'h5608, lfsr[31:16], 16'h0);
		end
		set_acc(32'hffffffff);
		run(16'h5608, 16'hffff, 16'h0);
		load_rpt(8'h02);
		for (i = 0; i < 3; i++) run(16'h8900, 16'h0, lfsr[15:0]);
		load_rpt(8'h03);
		run(16'h3e00, 16'hffff, 16'h0);
		i_dec.idle();
		rd(8'h14, 32'h0);
		lfsr = nxt(lfsr);
		set_acc(lfsr);
		for (i = 0; i < 4; i++) begin
			lfsr = nxt(lfsr);
			run({i[0] ? 7'h66 : 7'h60, i[1], 8'h00}, lfsr[31:16], lfsr[15:0]);
		end
		i_dec.idle();
		bus(1'b1, 8'h00, 32'h0);
		om = 1'b0;
		run(16'h3e05, 16'h1234, 16'h0);
		run(16'h5608, 16'h00ff, 16'h0);
		run(16'h8900, 16'h0, 16'h00ff);
		run(16'hcd00, 16'hf0f0, lfsr[15:0]);
		i_dec.idle();
		bus(1'b1, 8'h00, 32'h1);
		om = 1'b1;
		lfsr = nxt(lfsr);
		bus(1'b1, 8'h0c, lfsr);
		msk = lfsr[15:0];
		IRQ_SET_IN <= lfsr[31:16];
		pnd = lfsr[31:16];
		bus(1'b1, 8'h10, 32'h0000ffff);
		rd(8'h10, {16'h0, pnd});
		IRQ_SET_IN <= lfsr[31:16] & lfsr[15:0];
		run(16'h7626, 16'hffbe, 16'h0);
		run(16'h762f, 16'h0, 16'h0);
		i_dec.idle();
		rd(8'h0c, {16'h0, msk});
		rd(8'h04, {30'h0, flg[0], flg[1]});
		repeat (4) @(posedge CLK_IN);
		check("queue left", exp_q.size(), 32'h0);
		print_verdict();
	end
endmodule
